// >>> aux_pin_pkg.sv
// constants for the auxiliary pin configuration bank
`default_nettype none
package aux_pin_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PIN_COUNT = 4;
  localparam logic [7:0] PINS_5_6_CONFIG_ADDR = 8'h20;
  localparam logic [7:0] PINS_7_8_CONFIG_ADDR = 8'h21;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] RESERVED_MASK = 8'h44;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // field positions within one register
  localparam int HI_LEVEL_BIT = 7;
  localparam int HI_DIR_BIT = 5;
  localparam int HI_EN_BIT = 4;
  localparam int LO_LEVEL_BIT = 3;
  localparam int LO_DIR_BIT = 1;
  localparam int LO_EN_BIT = 0;
  // {direction, enable} pad modes
  typedef enum logic [1:0] {
    MODE_FUNC_OUT = 2'b00,
    MODE_GP_OUT = 2'b01,
    MODE_TRISTATE = 2'b10,
    MODE_GP_IN = 2'b11
  } pin_mode_t;
endpackage
`default_nettype wire

// >>> aux_pin_config_bank.sv
// register bank and pad control for auxiliary pins 5 to 8
//
// The implementer's own choice: strobed register access.
`default_nettype none
// Operation
// - drive local level only in general output mode
// - 00 functional output, 10 high impedance
// - 01 general output, 11 general input
// - upper pin uses bits 5 and 4
// - lower pin uses bits 1 and 0
// - pins 5/6 register at 0x20, resets zero
// - pins 7/8 register at 0x21, same layout
module aux_pin_config_bank (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] func_out,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  output logic [3:0] gp_in_level
);
  logic [7:0] pins_5_6_config_q;
  logic [7:0] pins_5_6_config_d;
  logic [7:0] pins_7_8_config_q;
  logic [7:0] pins_7_8_config_d;
  logic [7:0] reg_rdata_q;
  logic [7:0] reg_rdata_d;
  logic [3:0] gp_in_q;

  wire hit_56 = reg_addr == aux_pin_pkg::PINS_5_6_CONFIG_ADDR;
  wire hit_78 = reg_addr == aux_pin_pkg::PINS_7_8_CONFIG_ADDR;
  // reserved bits are storage only and reach no pad logic
  assign pins_5_6_config_d = (reg_write && hit_56) ? reg_wdata
                                                   : pins_5_6_config_q;
  assign pins_7_8_config_d = (reg_write && hit_78) ? reg_wdata
                                                   : pins_7_8_config_q;
  assign reg_rdata_d = hit_56 ? pins_5_6_config_q :
                       hit_78 ? pins_7_8_config_q :
                       aux_pin_pkg::UNMAPPED_READ;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pins_5_6_config_q <= aux_pin_pkg::CONFIG_RESET;
      pins_7_8_config_q <= aux_pin_pkg::CONFIG_RESET;
      reg_rdata_q <= aux_pin_pkg::UNMAPPED_READ;
      gp_in_q <= 4'h0;
    end
    else
    begin
      pins_5_6_config_q <= pins_5_6_config_d;
      pins_7_8_config_q <= pins_7_8_config_d;
      // read data valid only in the cycle after the strobe
      reg_rdata_q <= reg_read ? reg_rdata_d : aux_pin_pkg::UNMAPPED_READ;
      gp_in_q <= pin_in;
    end
  end
  assign reg_rdata = reg_rdata_q;

  // per-pin fields, index 0..3 = pins 5..8
  logic [3:0] level;
  logic [3:0] dir;
  logic [3:0] en;
  assign level = {pins_7_8_config_q[aux_pin_pkg::HI_LEVEL_BIT],
                  pins_7_8_config_q[aux_pin_pkg::LO_LEVEL_BIT],
                  pins_5_6_config_q[aux_pin_pkg::HI_LEVEL_BIT],
                  pins_5_6_config_q[aux_pin_pkg::LO_LEVEL_BIT]};
  assign dir = {pins_7_8_config_q[aux_pin_pkg::HI_DIR_BIT],
                pins_7_8_config_q[aux_pin_pkg::LO_DIR_BIT],
                pins_5_6_config_q[aux_pin_pkg::HI_DIR_BIT],
                pins_5_6_config_q[aux_pin_pkg::LO_DIR_BIT]};
  assign en = {pins_7_8_config_q[aux_pin_pkg::HI_EN_BIT],
               pins_7_8_config_q[aux_pin_pkg::LO_EN_BIT],
               pins_5_6_config_q[aux_pin_pkg::HI_EN_BIT],
               pins_5_6_config_q[aux_pin_pkg::LO_EN_BIT]};

  // pad outputs are combinational from register state so a mode change
  // lands on the pad in the cycle after the write
  genvar i;
  generate
    for (i = 0; i < aux_pin_pkg::PIN_COUNT; i++)
    begin : g_pin
      aux_pin_pkg::pin_mode_t mode;
      assign mode = aux_pin_pkg::pin_mode_t'({dir[i], en[i]});
      // remote control does not exist here, so gp output is always local
      assign pin_out[i] = (mode == aux_pin_pkg::MODE_GP_OUT) ? level[i] :
                          (mode == aux_pin_pkg::MODE_FUNC_OUT) ? func_out[i]
                                                                : 1'b0;
      assign pin_oe_n[i] = !((mode == aux_pin_pkg::MODE_FUNC_OUT) ||
                             (mode == aux_pin_pkg::MODE_GP_OUT));
      assign gp_in_level[i] = (mode == aux_pin_pkg::MODE_GP_IN) ?
                              gp_in_q[i] : 1'b0;
    end
  endgenerate

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence write_56_s;
    reg_write && hit_56;
  endsequence

  reg_write_56_a: assert property (
    write_56_s |=> pins_5_6_config_q == $past(reg_wdata))
    else $error("pins 5/6 config not stored");
  reg_write_78_a: assert property (
    reg_write && hit_78 |=> pins_7_8_config_q == $past(reg_wdata))
    else $error("pins 7/8 config not stored");
  read_back_a: assert property (
    reg_read && hit_56 && !reg_write |=> reg_rdata == pins_5_6_config_q)
    else $error("pins 5/6 read back wrong");
  gp_level_a: assert property (
    (write_56_s and reg_wdata[1:0] == 2'b01)
    |=> pin_out[0] == $past(reg_wdata[3]) && !pin_oe_n[0])
    else $error("pin 5 gp output level wrong");
  tristate_a: assert property (
    reg_write && hit_78 && reg_wdata[5:4] == 2'b10 |=> pin_oe_n[3])
    else $error("pin 8 not tristated");
  func_out_a: assert property (
    !pins_5_6_config_q[5] && !pins_5_6_config_q[4]
    |-> pin_out[1] == func_out[1] && !pin_oe_n[1])
    else $error("pin 6 functional output wrong");
  gp_input_a: assert property (
    pins_7_8_config_q[1:0] == 2'b11 |-> pin_oe_n[2] &&
    gp_in_level[2] == $past(pin_in[2]))
    else $error("pin 7 input path wrong");
  reserved_inert_a: assert property (
    pins_5_6_config_q[6] && pins_5_6_config_q[5:4] == 2'b01
    |-> pin_out[1] == pins_5_6_config_q[7])
    else $error("reserved bit changed pin 6");
  reset_zero_a: assert property (@(posedge ref_clk)
    $past(reset) |-> pins_5_6_config_q == 8'h00 &&
    pins_7_8_config_q == 8'h00)
    else $error("config not zero after reset");

  // named steps of a register access, shared by the checks below
  sequence write_78_s;
    reg_write && hit_78;
  endsequence

  sequence read_78_s;
    reg_read && hit_78;
  endsequence

  sequence read_unmapped_s;
    reg_read && !hit_56 && !hit_78;
  endsequence

  read_back_78_a: assert property (
    read_78_s |=> reg_rdata == pins_7_8_config_q)
    else $error("pins 7/8 read back wrong");

  // the read port falls back to zero outside the answer cycle, so a
  // stale value can never pass for a fresh one
  read_idle_zero_a: assert property (
    !reg_read |=> reg_rdata == aux_pin_pkg::UNMAPPED_READ)
    else $error("read data not zero outside answer cycle");

  unmapped_read_a: assert property (
    read_unmapped_s |=> reg_rdata == aux_pin_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");

  unmapped_write_a: assert property (
    reg_write && !hit_56 && !hit_78 |=> $stable(pins_5_6_config_q) &&
    $stable(pins_7_8_config_q))
    else $error("unmapped write changed a register");

  hold_56_a: assert property (
    !(reg_write && hit_56) |=> $stable(pins_5_6_config_q))
    else $error("pins 5/6 config changed without a write");

  hold_78_a: assert property (
    !(reg_write && hit_78) |=> $stable(pins_7_8_config_q))
    else $error("pins 7/8 config changed without a write");

  write_78_level_a: assert property (
    (write_78_s and reg_wdata[5:4] == 2'b01)
    |=> pin_out[3] == $past(reg_wdata[7]) && !pin_oe_n[3])
    else $error("pin 8 gp output level wrong");

  // upper pins decode bits 5 and 4, lower pins bits 1 and 0
  pin6_gp_out_a: assert property (
    pins_5_6_config_q[5:4] == 2'b01 |->
    pin_out[1] == pins_5_6_config_q[7] && !pin_oe_n[1])
    else $error("pin 6 gp output wrong");

  pin8_gp_out_a: assert property (
    pins_7_8_config_q[5:4] == 2'b01 |->
    pin_out[3] == pins_7_8_config_q[7] && !pin_oe_n[3])
    else $error("pin 8 gp output wrong");

  pin7_gp_out_a: assert property (
    pins_7_8_config_q[1:0] == 2'b01 |->
    pin_out[2] == pins_7_8_config_q[3] && !pin_oe_n[2])
    else $error("pin 7 gp output wrong");

  pin5_func_out_a: assert property (
    pins_5_6_config_q[1:0] == 2'b00 |->
    pin_out[0] == func_out[0] && !pin_oe_n[0])
    else $error("pin 5 functional output wrong");

  pin8_func_out_a: assert property (
    pins_7_8_config_q[5:4] == 2'b00 |->
    pin_out[3] == func_out[3] && !pin_oe_n[3])
    else $error("pin 8 functional output wrong");

  // a released pad drives low internally so nothing toggles behind it
  pin5_tristate_a: assert property (
    pins_5_6_config_q[1:0] == 2'b10 |-> pin_oe_n[0] && !pin_out[0])
    else $error("pin 5 not tristated");

  pin6_gp_in_a: assert property (
    pins_5_6_config_q[5:4] == 2'b11 |-> pin_oe_n[1] &&
    gp_in_level[1] == $past(pin_in[1]))
    else $error("pin 6 input path wrong");

  input_quiet_a: assert property (
    (gp_in_level & ~(dir & en)) == 4'h0)
    else $error("input level shown outside input mode");
endmodule
`default_nettype wire

// >>> pad_partner.sv
// external circuitry model on the four auxiliary pads
`default_nettype none
module pad_partner (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] ext_level,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pad shows the device level, a released one the far side's
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule
`default_nettype wire

// >>> aux_pin_config_bank_tb.sv
// self-checking bench for the auxiliary pin configuration bank
`default_nettype none
module aux_pin_config_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, reset = 1, reg_write = 0, reg_read = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [3:0] func_out = 4'hA, ext_level = 4'h6, pin_in, pin_out, pin_oe_n;
  logic [3:0] gp_in_level;
  int fail_count = 0, total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  aux_pin_config_bank uut (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .func_out(func_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .gp_in_level(gp_in_level));
  pad_partner far (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in));
  task chk(string n, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task rd(logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  function automatic logic [7:0] pad(logic [1:0] m, logic lv, f, e);
    return {5'h00, m == 2'b00 ? f : (m == 2'b01 ? lv : 1'b0), m[1],
      m == 2'b11 ? e : 1'b0};
  endfunction
  task t_reset;
    rd(8'h20, d); chk("cfg56", d, 8'h00);
    rd(8'h21, d); chk("cfg78", d, 8'h00);
    chk("pads", {pin_oe_n, pin_out}, {4'h0, func_out});
  endtask
  task t_modes;
    logic [1:0] m, h, x;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0]; h = ~m;
      wr(8'h20, {2'b00, h, 2'b10, m});
      wr(8'h21, {2'b00, h, 2'b10, m});
      @(posedge ref_clk);
      #1;
      for (int p = 0; p < 4; p++)
      begin
        x = p[0] ? h : m;
        chk("pad", {5'h00, pin_out[p], pin_oe_n[p], gp_in_level[p]},
          pad(x, ~p[0], func_out[p], ext_level[p]));
      end
    end
  endtask
  task t_reserved;
    wr(8'h21, 8'h44); wr(8'h20, 8'hB9); wr(8'h22, 8'hFF);
    rd(8'h21, d); chk("rsv", d, 8'h44);
    rd(8'h20, d); chk("cfg56", d, 8'hB9);
    rd(8'h22, d); chk("unmapped", d, 8'h00);
    chk("p78", {pin_oe_n[3:2], pin_out[3:2]}, {2'b00, func_out[3:2]});
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_modes();
    t_reserved();
    close_out();
  end
endmodule
`default_nettype wire
